// ===== verilog/cvw_pkg.sv
// Constants, register map and default tables of the configuration write interpreter
package cvw_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CVCMD = 8'h04;
  localparam logic [7:0] REG_CVRD = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_PROJ = 8'h10;
  localparam logic [7:0] REG_VREF = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_SOUND_BIT = 0;
  localparam int CTRL_EE1K_BIT = 1;
  localparam int CMD_RD_BIT = 31;
  localparam int CMD_NUM_LSB = 8;
  localparam int CMD_NUM_MSB = 17;
  localparam int CMD_VAL_MSB = 7;

  // ==========================================================
  // Variable numbers and widths
  localparam int CV_W = 10;
  localparam int CV_DEPTH = 1024;
  localparam logic [9:0] CV_VER = 10'h007;
  localparam logic [9:0] CV_ID = 10'h008;
  localparam logic [9:0] CV_VREF = 10'h039;
  localparam logic [9:0] CV_LAST = 10'h3FF;

  // ==========================================================
  // Identification variable commands
  localparam logic [7:0] ID_ALL_DEF = 8'h00;
  localparam logic [7:0] ID_RESTORE = 8'h08;
  localparam logic [7:0] ID_SAVE = 8'hFE;
  localparam logic [7:0] ID_LOAD = 8'hFF;
  localparam logic [7:0] SET_MIN = 8'h0A;
  localparam logic [7:0] SET_MAX = 8'h28;
  localparam logic [7:0] SET_A = 8'h0A;
  localparam logic [7:0] SET_B = 8'h0B;
  localparam logic [7:0] SET_NONE = 8'h00;

  // ==========================================================
  // Version variable modifiers
  localparam logic [7:0] VER_CLEAR = 8'h00;
  localparam logic [7:0] VER_T100 = 8'h6E;
  localparam logic [7:0] VER_T200 = 8'h78;
  localparam logic [7:0] VER_T300 = 8'h82;
  localparam logic [7:0] VER_P100 = 8'hD2;
  localparam logic [7:0] VER_P200 = 8'hDC;
  localparam logic [7:0] VER_DIGIT_LIM = 8'h64;
  localparam logic [7:0] VER_TEN = 8'h0A;
  localparam logic [11:0] OFF_STEP = 12'h064;

  // ==========================================================
  // Alternate format, speed steps, reference voltage
  localparam logic [9:0] ALT_CV_MIN = 10'h001;
  localparam logic [9:0] ALT_CV_MAX = 10'h04F;
  localparam logic [7:0] ALT_VAL_MAX = 8'h4F;
  localparam logic [7:0] STEPS_DCC = 8'h1C;
  localparam logic [7:0] STEPS_ALT = 8'h0E;
  localparam logic [7:0] VREF_AUTO = 8'h00;

  // Arbitrary neutral maker code and firmware number
  localparam logic [7:0] MAKER_ID_DEF = 8'h5A;
  localparam logic [7:0] FW_VER_DEF = 8'h21;

  // ==========================================================
  // Timing: headlight half period
  localparam int CLK_KHZ = 125000;
  localparam int BLINK_HALF_MS = 500;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

  // ==========================================================
  // State enumerations
  typedef enum logic [0:0] {ST_IDLE, ST_WALK} cvw_state_t;
  typedef enum logic [1:0] {SRC_DEF, SRC_BK, SRC_SAVE} cvw_src_t;
  typedef enum logic [1:0] {ME_IDLE, ME_OFF, ME_HELD, ME_ON} cvw_entry_t;

  // ==========================================================
  // Decoder defaults with configuration set overrides
  function automatic logic [7:0] cvw_def_val(input logic [9:0] n, input logic [7:0] set);
    logic [7:0] v;
    v = 8'h00;
    case (n)
      10'h001: v = 8'h03;
      10'h002: v = 8'h01;
      10'h003: v = 8'h02;
      10'h004: v = 8'h01;
      10'h005: v = 8'h01;
      10'h006: v = 8'h01;
      10'h009: v = 8'h37;
      10'h00E: v = 8'h43;
      10'h011: v = 8'hC0;
      10'h012: v = 8'h80;
      default: v = 8'h00;
    endcase
    if (set == SET_A) begin
      case (n)
        10'h002: v = 8'h04;
        10'h003: v = 8'h06;
        10'h004: v = 8'h02;
        10'h005: v = 8'hFC;
        10'h006: v = 8'h55;
        10'h009: v = 8'h5F;
        10'h00A: v = 8'h80;
        10'h01D: v = 8'h06;
        10'h038: v = 8'h21;
        10'h071: v = 8'hFF;
        10'h07A: v = 8'h1F;
        10'h090: v = 8'h80;
        10'h092: v = 8'h1E;
        10'h096: v = 8'hFF;
        default: v = v;
      endcase
    end
    if (set == SET_B) begin
      case (n)
        10'h003: v = 8'h03;
        10'h004: v = 8'h02;
        10'h009: v = 8'h58;
        10'h00D: v = 8'h01;
        10'h038: v = 8'h3D;
        10'h03A: v = 8'hAA;
        10'h070: v = 8'h24;
        10'h07C: v = 8'h80;
        10'h098: v = 8'h40;
        default: v = v;
      endcase
    end
    return v;
  endfunction : cvw_def_val

endpackage : cvw_pkg

// ===== verilog/cvw_sync.sv
// Three-stage input synchroniser with agreement filter
module cvw_sync
  import cvw_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } cvw_sync_regs_t;

  cvw_sync_regs_t r_r;
  cvw_sync_regs_t r_nxt;

  // First stage only feeds the second
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < W; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        r_nxt.q[i] = r_r.s2[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign q = r_r.q;

endmodule : cvw_sync

// ===== verilog/cvw_blink.sv
// Half-period divider giving a one-cycle toggle pulse while enabled
module cvw_blink
  import cvw_pkg::*;
#(
  parameter int HALF_CYC = BLINK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  output logic tick
);

  localparam int CW = $clog2(HALF_CYC + 1);

  // ==========================================================
  // State
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } cvw_blink_regs_t;

  cvw_blink_regs_t r_r;
  cvw_blink_regs_t r_nxt;

  // Restart from zero on enable so the first flash has full length
  always_comb begin
    r_nxt = r_r;
    r_nxt.tick = 1'b0;
    if (!en) begin
      r_nxt.cnt = '0;
    end else if (r_r.cnt == CW'(HALF_CYC - 1)) begin
      r_nxt.cnt = '0;
      r_nxt.tick = 1'b1;
    end else begin
      r_nxt.cnt = r_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign tick = r_r.tick;

endmodule : cvw_blink

// ===== verilog/cvw_top.sv
// Configuration variable write interpreter with APB register access
// Notes on behaviour
// - Identification variable reads give maker code; writes are commands, never stored.
// - Writing a set number restores set defaults, others decoder defaults; remembers set.
// - Writing 8 repeats the last hard reset with the remembered set.
// - Sound variants restore the sound project for 8 and set numbers; sets are not applied.
// - Writing 0 restores plain decoder defaults and forgets any set.
// - Non-sound with 1K storage: 254 saves a backup of all variables.
// - Non-sound with 1K storage: 255 reloads all variables from backup.
// - Ordinary variable writes are stored normally after any reset or set.
// - Variables are 8-bit weighted binary, bit 0 least, bit 7 worth 128.
// - Default speed interpretation is 28 steps.
// - Reference variable 0 means automatic; otherwise tenths of a volt.
// - Version variable writes never overwrite firmware number; they set modifiers.
// - Ones digit d adds 100 times d to the next written value.
// - Tens digit 1 adds 100 to the next written variable number.
// - 110, 120, 130 raise later variable numbers by 100, 200, 300.
// - Temporary address offset holds until track power is lost.
// - Writing 0 to version variable cancels any offset at once.
// - 210, 220 set the same offsets but keep them across power loss.
// - Alternate track format detected automatically: 14 steps, 80 addresses.
// - In alternate programming the front headlight flashes once per second.
// - Alternate programming starts in short mode: variables 1-79, values 0-79.
module cvw_top
  import cvw_pkg::*;
#(
  parameter int HALF_CYC = BLINK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic track_power_pin,
  input wire logic dir_hold_pin,
  input wire logic alt_format_pin,
  output logic headlight,
  output logic alt_prog,
  output logic [7:0] speed_steps,
  output logic ref_auto,
  output logic [7:0] ref_tenths
);

  // ==========================================================
  // State and memories
  typedef struct packed {
    cvw_state_t st;
    cvw_src_t src;
    logic [9:0] idx;
    logic [7:0] wset;
    logic rdy;
    logic err;
    logic [31:0] rdata;
    logic sound;
    logic ee1k;
    logic [7:0] set_cur;
    logic [7:0] rd_val;
    logic [1:0] off_tmp;
    logic [1:0] off_per;
    logic os_addr;
    logic [3:0] os_val;
    cvw_entry_t ent;
    logic prog;
    logic reject;
    logic headlight;
    logic [7:0] steps;
    logic ref_auto;
    logic [7:0] ref_tenths;
  } cvw_regs_t;

  cvw_regs_t r_r;
  cvw_regs_t r_nxt;

  logic [7:0] cv_mem [CV_DEPTH];
  // Backup copy; in sound variants it holds the sound project image
  logic [7:0] bk_mem [CV_DEPTH];

  logic mem_we;
  logic [9:0] mem_wa;
  logic [7:0] mem_wd;
  logic bk_we;
  logic [9:0] bk_wa;
  logic [7:0] bk_wd;

  // ==========================================================
  // Pin inputs
  logic [2:0] pins_s;
  logic pwr_s;
  logic dir_s;
  logic alt_s;
  logic tick;

  cvw_sync #(
    .W(3)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({alt_format_pin, dir_hold_pin, track_power_pin}),
    .q(pins_s)
  );

  assign pwr_s = pins_s[0];
  assign dir_s = pins_s[1];
  assign alt_s = pins_s[2];

  cvw_blink #(
    .HALF_CYC(HALF_CYC)
  ) u_blink (
    .pclk(pclk),
    .presetn(presetn),
    .en(r_r.prog),
    .tick(tick)
  );

  // ==========================================================
  // Command decode
  logic acc;
  logic setup;
  logic walking;
  logic cmd_go;
  logic is_rd;
  logic [9:0] raw_num;
  logic [7:0] raw_val;
  logic [1:0] eff_off;
  logic [11:0] num_sum;
  logic [11:0] val_sum;
  logic [9:0] eff_num;
  logic [7:0] eff_val;
  logic alt_bad;
  logic pwr_q;

  assign setup = psel && !penable;
  assign acc = psel && penable && r_r.rdy;
  assign walking = (r_r.st == ST_WALK);
  assign cmd_go = acc && pwrite && (paddr == REG_CVCMD) && !walking;
  assign is_rd = pwdata[CMD_RD_BIT];
  assign raw_num = pwdata[CMD_NUM_MSB:CMD_NUM_LSB];
  assign raw_val = pwdata[CMD_VAL_MSB:0];
  // Persistent offset wins over a temporary one
  assign eff_off = (r_r.off_per != 2'h0) ? r_r.off_per : r_r.off_tmp;
  assign num_sum = 12'(raw_num) + 12'(r_r.os_addr) * OFF_STEP + 12'(eff_off) * OFF_STEP;
  assign val_sum = 12'(raw_val) + 12'(r_r.os_val) * OFF_STEP;
  // Sums beyond range wrap; the station is trusted to stay within range
  assign eff_num = num_sum[9:0];
  assign eff_val = val_sum[7:0];
  assign alt_bad = r_r.prog && ((raw_num < ALT_CV_MIN) || (raw_num > ALT_CV_MAX)
                   || (raw_val > ALT_VAL_MAX));

  // ==========================================================
  // Next state
  always_comb begin
    r_nxt = r_r;
    mem_we = 1'b0;
    mem_wa = r_r.idx;
    mem_wd = 8'h00;
    bk_we = 1'b0;
    bk_wa = r_r.idx;
    bk_wd = 8'h00;
    r_nxt.rdy = 1'b0;

    // Bus slave: one access cycle, answer prepared in setup
    if (setup) begin
      r_nxt.rdy = 1'b1;
      r_nxt.err = 1'b0;
      r_nxt.rdata = 32'h0000_0000;
      case (paddr)
        REG_CTRL: begin
          r_nxt.rdata[CTRL_SOUND_BIT] = r_r.sound;
          r_nxt.rdata[CTRL_EE1K_BIT] = r_r.ee1k;
        end
        REG_CVCMD: begin
          r_nxt.err = pwrite && walking;
        end
        REG_CVRD: begin
          r_nxt.rdata[7:0] = r_r.rd_val;
        end
        REG_STAT: begin
          r_nxt.rdata = {4'h0, r_r.steps, r_r.off_per, r_r.off_tmp, r_r.set_cur,
                         3'h0, r_r.reject, r_r.prog, r_r.prog, alt_s, walking};
        end
        REG_PROJ: begin
          r_nxt.err = pwrite && walking;
        end
        REG_VREF: begin
          r_nxt.rdata[8:0] = {r_r.ref_auto, r_r.ref_tenths};
        end
        default: begin
          r_nxt.err = 1'b1;
        end
      endcase
    end

    if (acc && pwrite && (paddr == REG_CTRL)) begin
      r_nxt.sound = pwdata[CTRL_SOUND_BIT];
      r_nxt.ee1k = pwdata[CTRL_EE1K_BIT];
    end
    if (acc && pwrite && (paddr == REG_PROJ) && !walking) begin
      bk_we = 1'b1;
      bk_wa = raw_num;
      bk_wd = raw_val;
    end

    // Variable access
    if (cmd_go) begin
      r_nxt.reject = 1'b0;
      if (is_rd) begin
        if (raw_num == CV_ID) begin
          r_nxt.rd_val = MAKER_ID_DEF;
        end else if (raw_num == CV_VER) begin
          r_nxt.rd_val = FW_VER_DEF;
        end else begin
          r_nxt.rd_val = cv_mem[eff_num];
        end
      end else if (raw_num == CV_ID) begin
        r_nxt.src = SRC_DEF;
        r_nxt.idx = 10'h000;
        if (raw_val == ID_ALL_DEF) begin
          r_nxt.st = ST_WALK;
          r_nxt.wset = SET_NONE;
          r_nxt.set_cur = SET_NONE;
        end else if (raw_val == ID_RESTORE) begin
          r_nxt.st = ST_WALK;
          r_nxt.wset = r_r.set_cur;
          if (r_r.sound) begin
            r_nxt.src = SRC_BK;
          end
        end else if ((raw_val >= SET_MIN) && (raw_val <= SET_MAX)) begin
          r_nxt.st = ST_WALK;
          r_nxt.wset = raw_val;
          r_nxt.set_cur = raw_val;
          if (r_r.sound) begin
            r_nxt.src = SRC_BK;
          end
        end else if (raw_val == ID_SAVE && !r_r.sound && r_r.ee1k) begin
          r_nxt.st = ST_WALK;
          r_nxt.src = SRC_SAVE;
        end else if (raw_val == ID_LOAD && !r_r.sound && r_r.ee1k) begin
          r_nxt.st = ST_WALK;
          r_nxt.src = SRC_BK;
        end else begin
          r_nxt.reject = 1'b1;
        end
      end else if (raw_num == CV_VER) begin
        r_nxt.os_addr = 1'b0;
        r_nxt.os_val = 4'h0;
        case (raw_val)
          VER_CLEAR: begin
            r_nxt.off_tmp = 2'h0;
            r_nxt.off_per = 2'h0;
          end
          VER_T100: r_nxt.off_tmp = 2'h1;
          VER_T200: r_nxt.off_tmp = 2'h2;
          VER_T300: r_nxt.off_tmp = 2'h3;
          VER_P100: r_nxt.off_per = 2'h1;
          VER_P200: r_nxt.off_per = 2'h2;
          default: begin
            if (raw_val < VER_DIGIT_LIM) begin
              r_nxt.os_val = 4'(raw_val % VER_TEN);
              r_nxt.os_addr = ((raw_val / VER_TEN) == 8'h01);
            end else begin
              r_nxt.reject = 1'b1;
            end
          end
        endcase
      end else if (alt_bad) begin
        r_nxt.reject = 1'b1;
      end else begin
        mem_we = 1'b1;
        mem_wa = eff_num;
        mem_wd = eff_val;
        r_nxt.os_addr = 1'b0;
        r_nxt.os_val = 4'h0;
      end
    end

    // Restore and save walk, one variable per cycle
    if (walking) begin
      case (r_r.src)
        SRC_DEF: begin
          mem_we = 1'b1;
          mem_wd = cvw_def_val(r_r.idx, r_r.wset);
        end
        SRC_BK: begin
          mem_we = 1'b1;
          mem_wd = bk_mem[r_r.idx];
        end
        SRC_SAVE: begin
          bk_we = 1'b1;
          bk_wd = cv_mem[r_r.idx];
        end
        default: begin
          mem_we = 1'b0;
        end
      endcase
      r_nxt.idx = r_r.idx + 10'h001;
      if (r_r.idx == CV_LAST) begin
        r_nxt.st = ST_IDLE;
      end
    end

    // Power loss drops temporary offsets and alternate programming
    if (!pwr_s) begin
      r_nxt.off_tmp = 2'h0;
      r_nxt.os_addr = 1'b0;
      r_nxt.os_val = 4'h0;
      r_nxt.prog = 1'b0;
    end

    // Alternate format programming entry sequence
    case (r_r.ent)
      ME_IDLE: begin
        if (alt_s && !pwr_s) begin
          r_nxt.ent = ME_OFF;
        end
      end
      ME_OFF: begin
        if (pwr_s) begin
          r_nxt.ent = ME_IDLE;
        end else if (dir_s) begin
          r_nxt.ent = ME_HELD;
        end
      end
      ME_HELD: begin
        if (!dir_s) begin
          r_nxt.ent = ME_OFF;
        end else if (pwr_s) begin
          r_nxt.ent = ME_ON;
        end
      end
      ME_ON: begin
        if (!pwr_s) begin
          r_nxt.ent = ME_OFF;
        end else if (!dir_s) begin
          r_nxt.ent = ME_IDLE;
          r_nxt.prog = alt_s;
        end
      end
      default: r_nxt.ent = ME_IDLE;
    endcase

    if (!r_nxt.prog) begin
      r_nxt.headlight = 1'b0;
    end else if (tick) begin
      r_nxt.headlight = !r_r.headlight;
    end
    r_nxt.steps = alt_s ? STEPS_ALT : STEPS_DCC;
    r_nxt.ref_auto = (cv_mem[CV_VREF] == VREF_AUTO);
    r_nxt.ref_tenths = cv_mem[CV_VREF];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '0;
      r_r.st <= ST_IDLE;
      r_r.src <= SRC_DEF;
      r_r.ent <= ME_IDLE;
      r_r.steps <= STEPS_DCC;
      r_r.ref_auto <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Memories carry no reset; software restores defaults with a command
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      cv_mem[mem_wa] <= mem_wd;
    end
    if (bk_we) begin
      bk_mem[bk_wa] <= bk_wd;
    end
  end

  assign prdata = r_r.rdata;
  assign pready = r_r.rdy;
  assign pslverr = r_r.err;
  assign headlight = r_r.headlight;
  assign alt_prog = r_r.prog;
  assign speed_steps = r_r.steps;
  assign ref_auto = r_r.ref_auto;
  assign ref_tenths = r_r.ref_tenths;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cmd_wr;
  assign cmd_wr = cmd_go && !is_rd;

  sequence id_cmd_s(logic [7:0] v);
    cmd_wr && (raw_num == CV_ID) && (raw_val == v);
  endsequence

  sequence ver_cmd_s(logic [7:0] v);
    cmd_wr && (raw_num == CV_VER) && (raw_val == v) && pwr_s;
  endsequence

  maker_read_a: assert property (cmd_go && is_rd && raw_num == CV_ID
    |=> r_r.rd_val == MAKER_ID_DEF)
    else $error("maker code read wrong");
  all_default_a: assert property (id_cmd_s(ID_ALL_DEF)
    |=> walking && r_r.src == SRC_DEF && r_r.wset == SET_NONE && r_r.set_cur == SET_NONE)
    else $error("plain default restore not started");
  restore_set_a: assert property (id_cmd_s(ID_RESTORE) ##0 !r_r.sound
    |=> walking && r_r.wset == $past(r_r.set_cur))
    else $error("restore did not reuse remembered set");
  walk_len_a: assert property ($rose(walking) |-> walking [*8] ##0 r_r.idx == 10'h007)
    else $error("walk index does not advance");
  temp_off_a: assert property (ver_cmd_s(VER_T200) |=> r_r.off_tmp == 2'h2)
    else $error("temporary offset not set");
  cancel_off_a: assert property (ver_cmd_s(VER_CLEAR)
    |=> r_r.off_tmp == 2'h0 && r_r.off_per == 2'h0)
    else $error("offset not cancelled");
  power_drop_a: assert property ($fell(pwr_s) |=> r_r.off_tmp == 2'h0 && !r_r.prog
    && r_r.off_per == $past(r_r.off_per))
    else $error("power loss handling wrong");
  oneshot_clr_a: assert property (cmd_wr && mem_we && !walking
    |=> r_r.os_addr == 1'b0 && r_r.os_val == 4'h0)
    else $error("digit modifier not cleared");
  dark_idle_a: assert property (!r_r.prog |=> !r_r.headlight)
    else $error("headlight lit outside programming");
  alt_range_a: assert property (cmd_wr && r_r.prog && raw_num > ALT_CV_MAX
    && raw_num != CV_ID && raw_num != CV_VER |-> !mem_we ##1 r_r.reject)
    else $error("short mode range not enforced");

endmodule : cvw_top

// ===== verification/cvw_station.sv
// Command station model driving track power, direction hold and format pins
module cvw_station (
  input wire logic pclk,
  output logic power,
  output logic dir_hold,
  output logic alt_fmt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // Idle state: powered, no direction command
  initial begin
    power = 1'b1;
    dir_hold = 1'b0;
    alt_fmt = 1'b0;
  end

  // ==========================================
  // Pin sequences
  // Steps last 16 cycles: seconds scaled down, still well past the 3-flop sync
  task automatic hold();
    repeat (16) @(posedge pclk);
  endtask : hold

  task automatic set_fmt(input logic f);
    @(posedge pclk);
    alt_fmt <= f;
  endtask : set_fmt

  task automatic power_cycle();
    @(posedge pclk);
    power <= 1'b0;
    hold();
    power <= 1'b1;
    hold();
  endtask : power_cycle

  task automatic enter_prog();
    @(posedge pclk);
    power <= 1'b0;
    hold();
    dir_hold <= 1'b1;
    hold();
    power <= 1'b1;
    hold();
    dir_hold <= 1'b0;
    hold();
  endtask : enter_prog
endmodule : cvw_station

// ===== verification/test_cvw_top.sv
// Self-checking testbench of the configuration write interpreter
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, s); end end
module test_cvw_top
  import cvw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;
  typedef struct packed {logic [9:0] n; logic [7:0] v; logic [9:0] rn; logic [7:0] e;} cvw_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic power, dir_hold, alt_fmt, headlight, alt_prog, ref_auto, h, e;
  logic [7:0] paddr, speed_steps, ref_tenths;
  logic [31:0] pwdata, prdata, q;
  int fails, checked, n;
  // ==========================================
  // Write row, then read row: number, value, read number, expected
  cvw_row_t rows [16] = '{
    '{10'h008, 8'h00, 10'h001, 8'h03},
    '{10'h008, 8'h0A, 10'h002, 8'h04},
    '{10'h002, 8'h35, 10'h002, 8'h35},
    '{10'h008, 8'h08, 10'h002, 8'h04},
    '{10'h008, 8'h00, 10'h002, 8'h01},
    '{10'h007, 8'h01, 10'h008, MAKER_ID_DEF},
    '{10'h005, 8'h3C, 10'h005, 8'hA0},
    '{10'h005, 8'h3C, 10'h005, 8'h3C},
    '{10'h007, 8'h0A, 10'h007, FW_VER_DEF},
    '{10'h016, 8'h19, 10'h07A, 8'h19},
    '{10'h007, 8'h6E, 10'h007, FW_VER_DEF},
    '{10'h0A6, 8'h2D, 10'h0A6, 8'h2D},
    '{10'h007, 8'h78, 10'h007, FW_VER_DEF},
    '{10'h042, 8'h2E, 10'h042, 8'h2E},
    '{10'h007, 8'h00, 10'h10A, 8'h2E},
    '{10'h039, 8'h8C, 10'h039, 8'h8C}
  };

  cvw_top #(.HALF_CYC(HALF)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .track_power_pin(power), .dir_hold_pin(dir_hold),
    .alt_format_pin(alt_fmt), .headlight(headlight), .alt_prog(alt_prog),
    .speed_steps(speed_steps), .ref_auto(ref_auto), .ref_tenths(ref_tenths));
  cvw_station u_stn (.pclk(pclk), .power(power), .dir_hold(dir_hold), .alt_fmt(alt_fmt));

  // ==========================================
  // Bus tasks
  // An idle edge before each setup keeps one assignment per signal per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Walks take 1024 cycles; ends holding the status word in q
  task automatic cv_wr(input logic [9:0] cv, input logic [7:0] v);
    int k;
    apb(1'b1, REG_CVCMD, {1'b0, 13'h0000, cv, v});
    k = 0;
    do begin
      apb(1'b0, REG_STAT, 32'h0000_0000);
      k++;
    end while (q[0] !== 1'b0 && k < 600);
    if (q[0] !== 1'b0) fails++;
  endtask : cv_wr

  task automatic cv_rd(input logic [9:0] cv);
    apb(1'b1, REG_CVCMD, {1'b1, 13'h0000, cv, 8'h00});
    apb(1'b0, REG_CVRD, 32'h0000_0000);
  endtask : cv_rd

  task automatic complete_run();
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // ==========================================
  // Clock, watchdog, sequence
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (80000) @(posedge pclk);
    fails++;
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fails = 0;
    checked = 0;
    repeat (8) @(posedge pclk);
    `CHK("steps_rst", STEPS_DCC, speed_steps)
    `CHK("auto_rst", 1'b1, ref_auto)
    presetn <= 1'b1;
    foreach (rows[i]) begin
      cv_wr(rows[i].n, rows[i].v);
      cv_rd(rows[i].rn);
      `CHK("cv_read", rows[i].e, q[7:0])
    end
    `CHK("ref_auto", 1'b0, ref_auto)
    `CHK("ref_tenths", 8'h8C, ref_tenths)
    `CHK("steps", STEPS_DCC, speed_steps)
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    cv_wr(CV_ID, ID_SAVE);
    cv_wr(10'h001, 8'h11);
    cv_wr(CV_ID, ID_LOAD);
    cv_rd(10'h001);
    `CHK("backup", 8'h03, q[7:0])
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    cv_wr(CV_ID, ID_SAVE);
    `CHK("save_sound", 1'b1, q[4])
    apb(1'b1, REG_PROJ, {14'h0000, 10'h002, 8'h77});
    cv_wr(CV_ID, SET_A);
    cv_rd(10'h002);
    `CHK("project", 8'h77, q[7:0])
    apb(1'b1, REG_CTRL, 32'h0000_0000);
    cv_wr(CV_VER, VER_P200);
    u_stn.power_cycle();
    cv_wr(10'h000, 8'h07);
    cv_wr(CV_VER, VER_CLEAR);
    cv_rd(10'h0C8);
    `CHK("persist", 8'h07, q[7:0])
    u_stn.set_fmt(1'b1);
    repeat (8) @(posedge pclk);
    `CHK("alt_steps", STEPS_ALT, speed_steps)
    u_stn.enter_prog();
    `CHK("alt_prog", 1'b1, alt_prog)
    for (int r = 0; r < 2; r++) begin
      h = headlight;
      n = 0;
      while (headlight === h && n < 40) begin
        @(posedge pclk);
        n++;
      end
    end
    `CHK("blink", HALF, n)
    cv_wr(10'h050, 8'h01);
    `CHK("short_mode", 1'b1, q[4])
    // Writes while a walk runs are refused and must leave no trace
    apb(1'b1, REG_CVCMD, {1'b0, 13'h0000, CV_ID, ID_ALL_DEF});
    apb(1'b1, REG_CVCMD, {1'b0, 13'h0000, 10'h001, 8'h22});
    `CHK("busy_err", 1'b1, e)
    cv_wr(10'h001, 8'h22);
    cv_rd(10'h001);
    `CHK("busy_drop", 8'h03, q[7:0])
    apb(1'b0, 8'h18, 32'h0000_0000);
    `CHK("unmapped_err", 1'b1, e)
    complete_run();
  end
endmodule : test_cvw_top
